// ==== rtl/fcp_map.svh ====
// Register offsets, reset values and field positions for flash content protection
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH
// Register indices as printed (not multiples of four: byte address is index * 4)
`define FCP_IDX_ADDR_TOP 16'ha012
`define FCP_IDX_GUARD_LO 16'ha013
`define FCP_IDX_GUARD_HI 16'ha014
`define FCP_IDX_LOW_BOUND 16'ha025
`define FCP_IDX_HIGH_BOUND 16'ha026
`define FCP_IDX_CMD 16'ha020
`define FCP_IDX_ADDR_LOW 16'ha023
`define FCP_IDX_ADDR_HIGH 16'ha022
`define FCP_IDX_CMD_STAT 16'ha030
`define FCP_IDX_IRQ_STAT 16'ha031
`define FCP_IDX_IRQ_CLR 16'ha032
`define FCP_IDX_IRQ_EN 16'ha033
`define FCP_IDX_UNLOCK 16'ha034
// Reset values
`define FCP_RST_LOW_BOUND 8'hff
`define FCP_RST_HIGH_BOUND 8'h00
`define FCP_RST_BYTE 8'h00
// Fields
`define FCP_ENABLE_BIT 7
`define FCP_PAGE_TOP 8'hff
`define FCP_CMD_ERASE 5'h08
`define FCP_CMD_WRITE 5'h04
`define FCP_CMD_READ 5'h10
`define FCP_UNLOCK_KEY 8'ha5
`define FCP_ZERO_BYTE 8'h00
`define FCP_PAGE_ONE 8'h01
`define FCP_SECTOR_SHIFT 4
`define FCP_LOW_OFFSET 4'h1
`define FCP_HIGH_OFFSET 4'h9
`define FCP_RESP_OKAY 2'b00
`define FCP_RESP_SLVERR 2'b10
`endif

// ==== rtl/fcp_pkg.sv ====
// Types shared by the flash content protection block
`default_nettype none
package fcp_pkg;
	// Command issued to the flash array after checking
	typedef struct packed {
		logic [4:0] code;
		logic [15:0] addr;
	} fcp_cmd_t;
	// Command tracker states
	typedef enum logic [2:0] {
		FCP_IDLE = 3'b001,
		FCP_ISSUE = 3'b010,
		FCP_WAIT = 3'b100
	} fcp_state_t;
endpackage : fcp_pkg
`default_nettype wire

// ==== rtl/fcp_top.sv ====
// Flash content protection: zone checks, write-once read guard, AXI4-Lite registers
// Summary of operation
// - Each erase or write command written to the command register is checked against the zones and aborted with failure if inside.
// - Two zones exist, a low one from the bottom of flash and a high one up to the top.
// - The low bound counts 256-byte pages, and pages below the bound minus one are protected.
// - The low bound resets to all ones so the low zone covers pages 00 to fd after reset.
// - The high bound counts 256-byte pages, and pages above the bound plus one up to page ff are protected.
// - The high bound resets to zero so the high zone covers pages 02 to ff after reset.
// - Guarded addresses return zero to code reads and to flash byte read commands.
// - Both guard registers clear to zero on any reset.
// - Range bits can only be set by writing ones and only a reset clears them.
// - Writing 0x80 to the high guard register sets the update enable, and range bits change only while it is set.
// - Once any range bit is set the update enable clears and stays zero until reset.
// - Low guard bit n protects from (n+1)*4KB up, high guard bit n from (n+9)*4KB up.
// - With several range bits set the lowest one decides the start of the guarded region.
// - A refused command sets the failure flag, which stays until the next command.
// - Sector erase checks the sector given by the upper eight address bits.
`include "fcp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fcp_top
	import fcp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [17:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [17:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Code read port from the core
	input wire logic [15:0] code_addr,
	input wire logic [7:0] code_raw_data,
	output logic [7:0] code_data,
	// Flash array command port
	output fcp_cmd_t flash_cmd,
	output logic flash_cmd_valid,
	input wire logic flash_done,
	input wire logic [7:0] flash_raw_data,
	// Interrupt
	output logic irq
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic [7:0] addr_top_ff;
	logic [7:0] addr_high_ff;
	logic [7:0] addr_low_ff;
	logic [7:0] guard_lo_ff;
	logic [7:0] guard_hi_ff;
	logic [7:0] low_bound_ff;
	logic [7:0] high_bound_ff;
	logic [7:0] read_data_ff;
	logic fail_ff;
	logic busy_ff;
	logic unlock_ff;
	logic [1:0] irq_stat_ff;
	logic [1:0] irq_en_ff;
	fcp_state_t state_ff;
	fcp_cmd_t cmd_ff;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic aw_held_ff;
	logic w_held_ff;
	logic [17:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic [15:0] wr_idx;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic rd_fire;
	logic [15:0] rd_idx;
	logic wr_hit;
	logic rd_hit;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_idx = aw_addr_ff[17:2];
	assign wr_byte = w_data_ff[7:0];
	assign wr_lane = w_strb_ff[0];
	assign rd_fire = s_axi_arvalid && !rvalid_ff;
	assign rd_idx = s_axi_araddr[17:2];

	// Address and data may arrive in either order; hold each until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 18'h00000;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// Decode of known indices; unmapped ones answer SLVERR
	always_comb begin
		case (wr_idx)
			`FCP_IDX_ADDR_TOP, `FCP_IDX_ADDR_HIGH, `FCP_IDX_ADDR_LOW, `FCP_IDX_CMD,
			`FCP_IDX_GUARD_LO, `FCP_IDX_GUARD_HI, `FCP_IDX_LOW_BOUND, `FCP_IDX_HIGH_BOUND,
			`FCP_IDX_IRQ_CLR, `FCP_IDX_IRQ_EN, `FCP_IDX_UNLOCK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		case (rd_idx)
			`FCP_IDX_ADDR_TOP, `FCP_IDX_ADDR_HIGH, `FCP_IDX_ADDR_LOW, `FCP_IDX_CMD,
			`FCP_IDX_GUARD_LO, `FCP_IDX_GUARD_HI, `FCP_IDX_LOW_BOUND, `FCP_IDX_HIGH_BOUND,
			`FCP_IDX_CMD_STAT, `FCP_IDX_IRQ_STAT, `FCP_IDX_IRQ_CLR, `FCP_IDX_IRQ_EN,
			`FCP_IDX_UNLOCK: rd_hit = 1'b1;
			default: rd_hit = 1'b0;
		endcase
	end

	// Write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `FCP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read data is registered; write-only clear register reads as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `FCP_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
			case (rd_idx)
				`FCP_IDX_ADDR_TOP: rdata_ff <= {24'h000000, addr_top_ff};
				`FCP_IDX_ADDR_HIGH: rdata_ff <= {24'h000000, addr_high_ff};
				`FCP_IDX_ADDR_LOW: rdata_ff <= {24'h000000, addr_low_ff};
				`FCP_IDX_CMD: rdata_ff <= {24'h000000, read_data_ff};
				`FCP_IDX_GUARD_LO: rdata_ff <= {24'h000000, guard_lo_ff};
				`FCP_IDX_GUARD_HI: rdata_ff <= {24'h000000, guard_hi_ff};
				`FCP_IDX_LOW_BOUND: rdata_ff <= {24'h000000, low_bound_ff};
				`FCP_IDX_HIGH_BOUND: rdata_ff <= {24'h000000, high_bound_ff};
				`FCP_IDX_CMD_STAT: rdata_ff <= {29'h00000000, unlock_ff, busy_ff, fail_ff};
				`FCP_IDX_IRQ_STAT: rdata_ff <= {30'h00000000, irq_stat_ff};
				`FCP_IDX_IRQ_EN: rdata_ff <= {30'h00000000, irq_en_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Timed access guard and plain registers
	// ************************************************************
	logic guarded_wr;
	logic cmd_wr;
	assign cmd_wr = wr_fire && wr_lane && wr_idx == `FCP_IDX_CMD && state_ff == FCP_IDLE;
	assign guarded_wr = wr_fire && wr_lane && unlock_ff;

	// One protected write per unlock; any other write with byte lane 0 strobed relocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unlock_ff <= 1'b0;
		end else if (wr_fire && wr_lane) begin
			unlock_ff <= wr_idx == `FCP_IDX_UNLOCK && wr_byte == `FCP_UNLOCK_KEY;
		end
	end

	// Address bytes and zone bounds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_top_ff <= `FCP_RST_BYTE;
			addr_high_ff <= `FCP_RST_BYTE;
			addr_low_ff <= `FCP_RST_BYTE;
			low_bound_ff <= `FCP_RST_LOW_BOUND;
			high_bound_ff <= `FCP_RST_HIGH_BOUND;
		end else if (guarded_wr) begin
			if (wr_idx == `FCP_IDX_ADDR_TOP) addr_top_ff <= wr_byte;
			if (wr_idx == `FCP_IDX_ADDR_HIGH) addr_high_ff <= wr_byte;
			if (wr_idx == `FCP_IDX_ADDR_LOW) addr_low_ff <= wr_byte;
			if (wr_idx == `FCP_IDX_LOW_BOUND) low_bound_ff <= wr_byte;
			if (wr_idx == `FCP_IDX_HIGH_BOUND) high_bound_ff <= wr_byte;
		end
	end

	// ************************************************************
	// Write-once internal read guard
	// ************************************************************
	logic guard_en;
	logic [7:0] nxt_guard_lo;
	logic [6:0] nxt_guard_range_hi;
	assign guard_en = guard_hi_ff[`FCP_ENABLE_BIT];
	always_comb begin
		nxt_guard_lo = guard_lo_ff;
		nxt_guard_range_hi = guard_hi_ff[6:0];
		// Ones set range bits only while enabled
		if (guarded_wr && guard_en && wr_idx == `FCP_IDX_GUARD_LO)
			nxt_guard_lo = guard_lo_ff | wr_byte;
		if (guarded_wr && guard_en && wr_idx == `FCP_IDX_GUARD_HI)
			nxt_guard_range_hi = guard_hi_ff[6:0] | wr_byte[6:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_lo_ff <= `FCP_RST_BYTE;
			guard_hi_ff <= `FCP_RST_BYTE;
		end else begin
			guard_lo_ff <= nxt_guard_lo;
			guard_hi_ff[6:0] <= nxt_guard_range_hi;
			// Enable sticks at zero once any range bit is set
			if (nxt_guard_lo != `FCP_ZERO_BYTE || nxt_guard_range_hi != 7'h00)
				guard_hi_ff[`FCP_ENABLE_BIT] <= 1'b0;
			// Enable set by writing its bit
			else if (guarded_wr && wr_idx == `FCP_IDX_GUARD_HI && wr_byte[`FCP_ENABLE_BIT])
				guard_hi_ff[`FCP_ENABLE_BIT] <= 1'b1;
		end
	end

	// Lowest set bit gives the start sector; 0 means off
	logic [3:0] guard_start;
	always_comb begin
		guard_start = 4'h0;
		for (int i = 6; i >= 0; i--) begin
			if (guard_hi_ff[i]) guard_start = 4'(i) + `FCP_HIGH_OFFSET;
		end
		for (int i = 7; i >= 0; i--) begin
			if (guard_lo_ff[i]) guard_start = 4'(i) + `FCP_LOW_OFFSET;
		end
	end

	function automatic logic fcp_guarded(input logic [3:0] start, input logic [15:0] a);
		fcp_guarded = start != 4'h0 && a[15:12] >= start;
	endfunction : fcp_guarded

	// Code reads of guarded space return zero
	assign code_data = fcp_guarded(guard_start, code_addr) ? `FCP_ZERO_BYTE : code_raw_data;

	// ************************************************************
	// Command check and tracking
	// ************************************************************
	logic [15:0] cmd_addr;
	logic [7:0] cmd_page;
	logic zone_hit;
	logic known_cmd;
	logic is_modify;
	logic refuse;
	assign cmd_addr = {addr_high_ff, addr_low_ff};
	// Erase uses the sector of the upper eight bits
	assign cmd_page = cmd_addr[15:8];
	// Nine-bit compare: bound 00 low or ff high empties a zone, no wrap
	assign zone_hit = ({1'b0, cmd_page} + {1'b0, `FCP_PAGE_ONE} < {1'b0, low_bound_ff})
		|| ({1'b0, cmd_page} > {1'b0, high_bound_ff} + {1'b0, `FCP_PAGE_ONE});
	assign is_modify = wr_byte[4:0] == `FCP_CMD_ERASE || wr_byte[4:0] == `FCP_CMD_WRITE;
	assign known_cmd = is_modify || wr_byte[4:0] == `FCP_CMD_READ;
	// Refuse modifying commands in a zone, and unknown or out of range ones
	assign refuse = !known_cmd || addr_top_ff != `FCP_ZERO_BYTE || (is_modify && zone_hit);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= FCP_IDLE;
			cmd_ff <= '0;
			fail_ff <= 1'b0;
			busy_ff <= 1'b0;
			read_data_ff <= `FCP_RST_BYTE;
		end else begin
			case (state_ff)
				FCP_IDLE: begin
					if (cmd_wr && guarded_wr) begin
						// Failure stands until the next command
						fail_ff <= refuse;
						if (!refuse) begin
							cmd_ff <= '{code: wr_byte[4:0], addr: cmd_addr};
							busy_ff <= 1'b1;
							state_ff <= FCP_ISSUE;
						end
					end
				end
				FCP_ISSUE: state_ff <= FCP_WAIT;
				FCP_WAIT: begin
					if (flash_done) begin
						busy_ff <= 1'b0;
						state_ff <= FCP_IDLE;
						// Byte reads of guarded space return zero
						if (cmd_ff.code == `FCP_CMD_READ)
							read_data_ff <= fcp_guarded(guard_start, cmd_ff.addr)
								? `FCP_ZERO_BYTE : flash_raw_data;
					end
				end
				default: state_ff <= FCP_IDLE;
			endcase
		end
	end
	assign flash_cmd = cmd_ff;
	assign flash_cmd_valid = state_ff == FCP_ISSUE;

	// ************************************************************
	// Interrupts: bit0 refused, bit1 done
	// ************************************************************
	logic [1:0] irq_evt;
	assign irq_evt = {state_ff == FCP_WAIT && flash_done, cmd_wr && guarded_wr && refuse};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= 2'b00;
			irq_en_ff <= 2'b00;
		end else begin
			// Set wins over a clear in the same cycle
			if (wr_fire && wr_lane && wr_idx == `FCP_IDX_IRQ_CLR)
				irq_stat_ff <= (irq_stat_ff & ~wr_byte[1:0]) | irq_evt;
			else
				irq_stat_ff <= irq_stat_ff | irq_evt;
			if (wr_fire && wr_lane && wr_idx == `FCP_IDX_IRQ_EN)
				irq_en_ff <= wr_byte[1:0];
		end
	end
	assign irq = |(irq_stat_ff & irq_en_ff);

	// ************************************************************
	// Assertions
	// ************************************************************
	a_refuse_no_issue: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == FCP_IDLE && cmd_wr && guarded_wr && refuse) |=> fail_ff && state_ff == FCP_IDLE)
		else $error("Refused command was issued");
	a_low_zone_fail: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == FCP_IDLE && cmd_wr && guarded_wr && is_modify
			&& cmd_page < low_bound_ff && cmd_page != low_bound_ff - `FCP_PAGE_ONE) |=> fail_ff)
		else $error("Low zone write not refused");
	a_high_zone_fail: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == FCP_IDLE && cmd_wr && guarded_wr && is_modify
			&& cmd_page > high_bound_ff && cmd_page != high_bound_ff + `FCP_PAGE_ONE) |=> fail_ff)
		else $error("High zone write not refused");
	a_code_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(guard_lo_ff[1:0] != 2'b00 && code_addr[15:13] != 3'b000) |-> code_data == `FCP_ZERO_BYTE)
		else $error("Guarded code read leaked data");
	a_guard_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> ((guard_lo_ff & $past(guard_lo_ff)) == $past(guard_lo_ff)))
		else $error("Guard bit cleared without reset");
	a_enable_stuck: assert property (@(posedge aclk) disable iff (!aresetn)
		(guard_lo_ff != `FCP_ZERO_BYTE || guard_hi_ff[6:0] != 7'h00) |-> !guard_en)
		else $error("Update enable survived range set");
	a_locked_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && !unlock_ff) |=> $stable(low_bound_ff) && $stable(high_bound_ff))
		else $error("Bound changed without unlock");
	a_fail_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(fail_ff && !(cmd_wr && guarded_wr)) |=> fail_ff)
		else $error("Failure flag dropped early");
	a_issue_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_cmd_valid |=> !flash_cmd_valid ##0 busy_ff)
		else $error("Issue pulse malformed");

endmodule : fcp_top
`default_nettype wire

// ==== test/fcp_flash_model.sv ====
// Behavioural flash array that answers checked commands from the protection block
`timescale 1ns/1ps
`default_nettype none
module fcp_flash_model
	import fcp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Command side
	input wire fcp_cmd_t flash_cmd,
	input wire logic flash_cmd_valid,
	output logic flash_done,
	output logic [7:0] flash_raw_data
);
	logic [7:0] cnt_ff;
	logic [15:0] addr_ff;
	logic done_ff;
	logic [7:0] data_ff;

	// Odd addresses answer slowly, even ones at once, so both paces get used
	// Read data is only valid with done; otherwise it toggles so stale bytes never pass
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= 8'h00;
			addr_ff <= 16'h0000;
			done_ff <= 1'b0;
			data_ff <= 8'h00;
		end else begin
			done_ff <= 1'b0;
			data_ff <= ~data_ff;
			if (flash_cmd_valid) begin
				cnt_ff <= flash_cmd.addr[0] ? 8'h14 : 8'h01;
				addr_ff <= flash_cmd.addr;
			end else if (cnt_ff != 8'h00) begin
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01) begin
					done_ff <= 1'b1;
					data_ff <= addr_ff[7:0] ^ 8'h3c;
				end
			end
		end
	end

	assign flash_done = done_ff;
	assign flash_raw_data = data_ff;
endmodule : fcp_flash_model
`default_nettype wire

// ==== test/tb_flash_content_protection.sv ====
// Self-checking bench for zone checks, read guard, interrupt and register bus
`include "fcp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_flash_content_protection
	import fcp_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, flash_cmd_valid, flash_done, irq;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, last_resp;
	logic [15:0] code_addr;
	logic [7:0] code_raw_data, code_data, flash_raw_data;
	fcp_cmd_t flash_cmd;
	int n_fail, n_checks;

	fcp_top fcp_top_inst(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .code_addr(code_addr), .code_raw_data(code_raw_data),
		.code_data(code_data), .flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid),
		.flash_done(flash_done), .flash_raw_data(flash_raw_data), .irq(irq));
	fcp_flash_model fcp_flash_model_inst(.aclk(aclk), .aresetn(aresetn),
		.flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid),
		.flash_done(flash_done), .flash_raw_data(flash_raw_data));

	// Free-running 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ******************************
	// Helpers
	// ******************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// A wait that runs out counts as a mismatch and ends the run
	task automatic hang();
		$display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		n_fail++;
		stop_test();
	endtask : hang

	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	// Address and data go out together; each drops on its own ready
	task automatic axw(input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 200);
		if (n >= 200) hang();
		last_resp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [15:0] idx, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 200);
		if (n >= 200) hang();
		d = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask : axr

	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		axr(idx, d);
		chk(d, {24'h000000, exp});
	endtask : rdc

	// Protected registers need the one-shot key right before each write
	task automatic pw(input logic [15:0] idx, input logic [7:0] d);
		axw(`FCP_IDX_UNLOCK, `FCP_UNLOCK_KEY);
		axw(idx, d);
	endtask : pw

	task automatic code_chk(input logic [15:0] a, input logic [7:0] raw, input logic [7:0] exp);
		@(posedge aclk);
		code_addr <= a;
		code_raw_data <= raw;
		@(posedge aclk);
		chk({24'h000000, code_data}, {24'h000000, exp});
	endtask : code_chk

	// Issue one command, wait out busy, then judge the failure flag
	task automatic run_cmd(input logic [4:0] c, input logic [7:0] top, input logic [15:0] a,
		input logic fexp);
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h00000002;
		pw(`FCP_IDX_ADDR_TOP, top);
		pw(`FCP_IDX_ADDR_HIGH, a[15:8]);
		pw(`FCP_IDX_ADDR_LOW, a[7:0]);
		pw(`FCP_IDX_CMD, {3'b000, c});
		repeat (3) @(posedge aclk);
		while (s[1] !== 1'b0 && n < 50) begin
			axr(`FCP_IDX_CMD_STAT, s);
			n++;
		end
		if (n >= 50) hang();
		chk({31'h0, s[0]}, {31'h0, fexp});
	endtask : run_cmd

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_reset();
		logic [31:0] d;
		rdc(`FCP_IDX_LOW_BOUND, 8'hff);
		rdc(`FCP_IDX_HIGH_BOUND, 8'h00);
		rdc(`FCP_IDX_GUARD_LO, 8'h00);
		rdc(`FCP_IDX_GUARD_HI, 8'h00);
		axw(`FCP_IDX_LOW_BOUND, 8'h10);
		rdc(`FCP_IDX_LOW_BOUND, 8'hff);
		axr(16'h0040, d);
		chk({30'h0, last_resp}, {30'h0, `FCP_RESP_SLVERR});
		$display("reset test done");
	endtask : t_reset

	task automatic t_zones();
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'h8000, 1'b1);
		pw(`FCP_IDX_LOW_BOUND, 8'h05);
		pw(`FCP_IDX_HIGH_BOUND, 8'hf0);
		rdc(`FCP_IDX_LOW_BOUND, 8'h05);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'h0300, 1'b1);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'h0400, 1'b0);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'hf100, 1'b0);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'hf2ff, 1'b1);
		run_cmd(`FCP_CMD_ERASE, 8'h00, 16'h03ff, 1'b1);
		run_cmd(`FCP_CMD_ERASE, 8'h00, 16'h0401, 1'b0);
		run_cmd(5'h01, 8'h00, 16'h0400, 1'b1);
		run_cmd(`FCP_CMD_WRITE, 8'h01, 16'h0400, 1'b1);
		run_cmd(`FCP_CMD_READ, 8'h00, 16'hff03, 1'b0);
		rdc(`FCP_IDX_CMD, 8'h3f);
		// Extreme bounds leave both zones empty; a wrapping compare would protect all
		pw(`FCP_IDX_LOW_BOUND, 8'h00);
		pw(`FCP_IDX_HIGH_BOUND, 8'hff);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'h0000, 1'b0);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'hff00, 1'b0);
		$display("zone test done");
	endtask : t_zones

	task automatic t_irq();
		axw(`FCP_IDX_IRQ_CLR, 8'h03);
		axw(`FCP_IDX_IRQ_EN, 8'h01);
		// Zones are empty now, so the refusal comes from an out of range address
		run_cmd(`FCP_CMD_WRITE, 8'h01, 16'h0000, 1'b1);
		chk({31'h0, irq}, 32'h1);
		rdc(`FCP_IDX_IRQ_STAT, 8'h01);
		axw(`FCP_IDX_IRQ_CLR, 8'h01);
		chk({31'h0, irq}, 32'h0);
		run_cmd(`FCP_CMD_WRITE, 8'h00, 16'h0500, 1'b0);
		chk({31'h0, irq}, 32'h0);
		rdc(`FCP_IDX_IRQ_STAT, 8'h02);
		axw(`FCP_IDX_IRQ_EN, 8'h03);
		chk({31'h0, irq}, 32'h1);
		axw(`FCP_IDX_IRQ_CLR, 8'h02);
		chk({31'h0, irq}, 32'h0);
		$display("interrupt test done");
	endtask : t_irq

	task automatic t_guard();
		code_chk(16'h3000, 8'h5a, 8'h5a);
		pw(`FCP_IDX_GUARD_LO, 8'h04);
		rdc(`FCP_IDX_GUARD_LO, 8'h00);
		pw(`FCP_IDX_GUARD_HI, 8'h80);
		rdc(`FCP_IDX_GUARD_HI, 8'h80);
		pw(`FCP_IDX_GUARD_LO, 8'h06);
		rdc(`FCP_IDX_GUARD_LO, 8'h06);
		rdc(`FCP_IDX_GUARD_HI, 8'h00);
		pw(`FCP_IDX_GUARD_LO, 8'h01);
		pw(`FCP_IDX_GUARD_HI, 8'h80);
		rdc(`FCP_IDX_GUARD_LO, 8'h06);
		rdc(`FCP_IDX_GUARD_HI, 8'h00);
		code_chk(16'h1fff, 8'h5a, 8'h5a);
		code_chk(16'h2000, 8'h5a, 8'h00);
		code_chk(16'hffff, 8'ha5, 8'h00);
		run_cmd(`FCP_CMD_READ, 8'h00, 16'h2003, 1'b0);
		rdc(`FCP_IDX_CMD, 8'h00);
		do_reset();
		rdc(`FCP_IDX_GUARD_LO, 8'h00);
		code_chk(16'h2000, 8'h5a, 8'h5a);
		pw(`FCP_IDX_GUARD_HI, 8'h80);
		pw(`FCP_IDX_GUARD_HI, 8'h84);
		rdc(`FCP_IDX_GUARD_HI, 8'h04);
		code_chk(16'hafff, 8'h11, 8'h11);
		code_chk(16'hb000, 8'h11, 8'h00);
		$display("guard test done");
	endtask : t_guard

	// Every input has a value at time zero; byte lane 0 carries all registers
	initial begin
		n_fail = 0;
		n_checks = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 18'h00000;
		araddr = 18'h00000;
		wdata = 32'h00000000;
		wstrb = 4'h1;
		code_addr = 16'h0000;
		code_raw_data = 8'h00;
		do_reset();
		t_reset();
		t_zones();
		t_irq();
		t_guard();
		stop_test();
	end
endmodule : tb_flash_content_protection
`default_nettype wire
